// >>> rtl/popc_params.svh
// Offsets, field positions, reset values and timing of the config bank
`ifndef POPC_PARAMS_SVH
`define POPC_PARAMS_SVH
// Register offsets within a page
`define POPC_OFF_PAGE      8'hff
`define POPC_OFF_DRV       8'h66
`define POPC_OFF_MISC      8'h67
`define POPC_OFF_STATUS    8'h02
`define POPC_OFF_NOTIFY    8'h03
`define POPC_OFF_MASK      8'h04
`define POPC_SHADOW_LO     8'h10
`define POPC_SHADOW_HI     8'h2f
`define POPC_FRAC_LO       8'h2c
// Page numbers
`define POPC_PAGE_OUT      8'h00
`define POPC_PAGE_PLL_A    8'h01
// Field positions
`define POPC_DRV_MSB       2
`define POPC_DLY_LO_MSB    4
`define POPC_DLY_LO_LSB    3
`define POPC_DIVHI_MSB     7
`define POPC_DIVHI_LSB     6
`define POPC_DLY_HI_BIT    4
`define POPC_PIN_MSB       3
`define POPC_LOL_BIT       0
// Reset values
`define POPC_RST_PAGE      8'h00
`define POPC_RST_DRV       8'h00
`define POPC_RST_MISC      8'h00
`define POPC_RST_SHADOW    8'h00
`define POPC_RST_NOTIFY    1'b1
`define POPC_RST_MASK      1'b1
// Fine delay step and its largest count
`define POPC_DLY_STEP_PS   30
`define POPC_DLY_MAX_STEPS 3'h4
`endif

// >>> rtl/popc_pkg.sv
// Types shared by the paged PLL configuration bank
package popc_pkg;
	typedef enum logic [2:0] {
		POPC_DRV_LVDS    = 3'h0,
		POPC_DRV_LVPECL  = 3'h1,
		POPC_DRV_CML     = 3'h2,
		POPC_DRV_HCSL    = 3'h3,
		POPC_DRV_LVDS_HI = 3'h4,
		POPC_DRV_LVPECL2 = 3'h5
	} popc_drv_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} popc_req_t;

	typedef struct packed {
		logic [1:0] div_hi;
		logic [2:0] delay_steps;
		popc_drv_t  drv;
		logic       drv_ok;
		logic       ext_term;
		logic       pull_up;
		logic       pull_down;
		logic       cmos_p;
		logic       cmos_n;
		logic       pin_ok;
	} popc_out_cfg_t;
endpackage

// >>> rtl/popc_lock_mon.sv
// Loss-of-lock pin synchroniser, live status, sticky notify and mask
`timescale 1ns/1ps
`include "popc_params.svh"
module popc_lock_mon
	import popc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic clock_i,
	input  wire logic reset_n_i,
	input  wire logic ce_i,
	// Raw loss-of-lock level from the PLL
	input  wire logic lol_pin_i,
	// Register writes
	input  wire logic notify_clr_i,
	input  wire logic mask_wr_i,
	input  wire logic mask_wdata_i,
	// State
	output logic      live_o,
	output logic      sticky_o,
	output logic      mask_o,
	output logic      notify_o
);
	logic s1_q, s2_q, s3_q;
	logic live_q, live_d;
	logic sticky_q, sticky_d;
	logic mask_q, mask_d;
	logic notify_q, notify_d;

	// Next state: live follows only once the last two stages agree
	always_comb
	begin
		live_d   = (s2_q == s3_q) ? s3_q : live_q;
		sticky_d = live_q | (sticky_q & ~notify_clr_i);
		mask_d   = mask_wr_i ? mask_wdata_i : mask_q;
		notify_d = sticky_q & ~mask_q;
	end

	// Registers; the first sync stage feeds only the second
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s1_q     <= 1'b0;
			s2_q     <= 1'b0;
			s3_q     <= 1'b0;
			live_q   <= 1'b0;
			sticky_q <= `POPC_RST_NOTIFY;
			mask_q   <= `POPC_RST_MASK;
			notify_q <= 1'b0;
		end
		else if (ce_i)
		begin
			s1_q     <= lol_pin_i;
			s2_q     <= s1_q;
			s3_q     <= s2_q;
			live_q   <= live_d;
			sticky_q <= sticky_d;
			mask_q   <= mask_d;
			notify_q <= notify_d;
		end
	end

	assign live_o   = live_q;
	assign sticky_o = sticky_q;
	assign mask_o   = mask_q;
	assign notify_o = notify_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	live_follows_a: assert property (
		ce_i && s2_q == s3_q |=> live_q == $past(s3_q))
		else $error("live lock status did not follow synchroniser");
	sticky_holds_a: assert property (
		ce_i && live_q |=> sticky_q)
		else $error("sticky bit lost a loss-of-lock event");
	notify_gate_a: assert property (
		ce_i && sticky_q && !mask_q |=> notify_q)
		else $error("unmasked sticky did not notify");
endmodule

// >>> rtl/popc_config_regs.sv
// Paged output and PLL configuration register bank
`timescale 1ns/1ps
`include "popc_params.svh"
// How it works
// - Page register at FFh on every page
// - PLL page 10h-2Fh hold shadow config
// - First PLL ignores feedback-two fraction
// - Driver standard three-bit code decoded
// - Bits 7:6 hold divider bits 25:24
// - Fine delay code gives 0-4 30ps steps
// - Four-bit pin-use code selects output mode
// - Register 67h read/write, resets zero
// - Status bit 0 is live loss-of-lock
// - Sticky notify latches, mask gates it
module popc_config_regs
	import popc_pkg::*;
#(
	parameter int NUM_PLL = 4
)
(
	// Clock, reset, enable
	input  wire logic                 clock_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 ce_i,
	// Register port
	input  wire popc_req_t            req_i,
	output logic [7:0]                rdata_o,
	output logic                      rvalid_o,
	// PLL lock pins
	input  wire logic [NUM_PLL-1:0]   lol_i,
	// Decoded output settings
	output popc_out_cfg_t             out_cfg_o,
	// Feedback-two fraction per PLL
	output logic [NUM_PLL*32-1:0]     frac_n2_o,
	output logic [NUM_PLL-1:0]        frac_valid_o,
	// Lock notification per PLL
	output logic [NUM_PLL-1:0]        notify_o
);
	// Elaboration check; the PLL select is two bits wide
	if (NUM_PLL < 1 || NUM_PLL > 4)
	begin : g_bad_num_pll
		$error("NUM_PLL must be 1 to 4");
	end

	localparam int SH_N = 32;

	logic [7:0]          page_q, page_d;
	logic [7:0]          drv_q, drv_d;
	logic [7:0]          misc_q, misc_d;
	logic [7:0]          shadow_q [NUM_PLL][SH_N];
	logic [7:0]          shadow_d [NUM_PLL][SH_N];
	logic [7:0]          rdata_q, rdata_d;
	logic                rvalid_q, rvalid_d;
	popc_out_cfg_t       cfg_q, cfg_d;
	logic [NUM_PLL*32-1:0] frac_q, frac_d;
	logic [NUM_PLL-1:0]  fvalid_q, fvalid_d;

	logic                on_out_page;
	logic                on_pll_page;
	logic [1:0]          pll_sel;
	logic                in_shadow;
	logic [4:0]          sh_idx;
	logic [7:0]          page_rel;
	logic [NUM_PLL-1:0]  live, sticky, mask, notify;
	logic [NUM_PLL-1:0]  notify_clr, mask_wr;

	// Page decode; accesses follow the page held now
	always_comb
	begin
		page_rel    = page_q - `POPC_PAGE_PLL_A;
		on_out_page = (page_q == `POPC_PAGE_OUT);
		on_pll_page = (page_q >= `POPC_PAGE_PLL_A) &&
			(page_rel < 8'(NUM_PLL));
		pll_sel     = page_rel[1:0];
		in_shadow   = (req_i.addr >= `POPC_SHADOW_LO) &&
			(req_i.addr <= `POPC_SHADOW_HI);
		sh_idx      = 5'(req_i.addr - `POPC_SHADOW_LO);
	end

	// Lock monitor strobes for the addressed PLL only
	always_comb
	begin
		notify_clr = '0;
		mask_wr    = '0;
		if (req_i.wr && on_pll_page)
		begin
			if (req_i.addr == `POPC_OFF_NOTIFY)
				notify_clr[pll_sel] = req_i.wdata[`POPC_LOL_BIT];
			if (req_i.addr == `POPC_OFF_MASK)
				mask_wr[pll_sel] = 1'b1;
		end
	end

	// One monitor per PLL
	generate
		for (genvar p = 0; p < NUM_PLL; p++)
		begin : g_mon
			popc_lock_mon u_mon (
				.clock_i      (clock_i),
				.reset_n_i    (reset_n_i),
				.ce_i         (ce_i),
				.lol_pin_i    (lol_i[p]),
				.notify_clr_i (notify_clr[p]),
				.mask_wr_i    (mask_wr[p]),
				.mask_wdata_i (req_i.wdata[`POPC_LOL_BIT]),
				.live_o       (live[p]),
				.sticky_o     (sticky[p]),
				.mask_o       (mask[p]),
				.notify_o     (notify[p])
			);
		end
	endgenerate

	// Register writes
	always_comb
	begin
		page_d   = page_q;
		drv_d    = drv_q;
		misc_d   = misc_q;
		shadow_d = shadow_q;
		if (req_i.wr)
		begin
			if (req_i.addr == `POPC_OFF_PAGE)
				page_d = req_i.wdata;
			else if (on_out_page && req_i.addr == `POPC_OFF_DRV)
				drv_d = req_i.wdata;
			else if (on_out_page && req_i.addr == `POPC_OFF_MISC)
				misc_d = req_i.wdata;
			else if (on_pll_page && in_shadow)
				shadow_d[pll_sel][sh_idx] = req_i.wdata;
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb
	begin
		rdata_d  = 8'h00;
		rvalid_d = req_i.rd;
		if (req_i.rd)
		begin
			if (req_i.addr == `POPC_OFF_PAGE)
				rdata_d = page_q;
			else if (on_out_page && req_i.addr == `POPC_OFF_DRV)
				rdata_d = drv_q;
			else if (on_out_page && req_i.addr == `POPC_OFF_MISC)
				rdata_d = misc_q;
			else if (on_pll_page && in_shadow)
				rdata_d = shadow_q[pll_sel][sh_idx];
			else if (on_pll_page && req_i.addr == `POPC_OFF_STATUS)
				rdata_d = {7'h00, live[pll_sel]};
			else if (on_pll_page && req_i.addr == `POPC_OFF_NOTIFY)
				rdata_d = {7'h00, sticky[pll_sel]};
			else if (on_pll_page && req_i.addr == `POPC_OFF_MASK)
				rdata_d = {7'h00, mask[pll_sel]};
		end
	end

	// Output decode; bad codes fall back to a safe LVDS/external mode
	always_comb
	begin
		logic [2:0] code;
		code = {misc_q[`POPC_DLY_HI_BIT],
			drv_q[`POPC_DLY_LO_MSB:`POPC_DLY_LO_LSB]};
		cfg_d = '0;
		cfg_d.div_hi = misc_q[`POPC_DIVHI_MSB:`POPC_DIVHI_LSB];
		// Codes above four clamp; the delay line has four taps
		cfg_d.delay_steps = (code > `POPC_DLY_MAX_STEPS) ?
			`POPC_DLY_MAX_STEPS : code;
		cfg_d.drv_ok = 1'b1;
		case (drv_q[`POPC_DRV_MSB:0])
			3'h0: cfg_d.drv = POPC_DRV_LVDS;
			3'h1: cfg_d.drv = POPC_DRV_LVPECL;
			3'h2: cfg_d.drv = POPC_DRV_CML;
			3'h3: cfg_d.drv = POPC_DRV_HCSL;
			3'h4: cfg_d.drv = POPC_DRV_LVDS_HI;
			3'h5: cfg_d.drv = POPC_DRV_LVPECL2;
			default:
			begin
				cfg_d.drv    = POPC_DRV_LVDS;
				cfg_d.drv_ok = 1'b0;
			end
		endcase
		cfg_d.pin_ok = 1'b1;
		case (misc_q[`POPC_PIN_MSB:0])
			4'h0: cfg_d.ext_term  = 1'b1;
			4'h2: cfg_d.pull_up   = 1'b1;
			4'h1: cfg_d.pull_down = 1'b1;
			4'h4: cfg_d.cmos_p    = 1'b1;
			4'h8: cfg_d.cmos_n    = 1'b1;
			4'hc:
			begin
				cfg_d.cmos_p = 1'b1;
				cfg_d.cmos_n = 1'b1;
			end
			default:
			begin
				cfg_d.ext_term = 1'b1;
				cfg_d.pin_ok   = 1'b0;
			end
		endcase
	end

	// Fraction per PLL; the first PLL has no fraction on this divider
	always_comb
	begin
		frac_d   = '0;
		fvalid_d = '0;
		for (int p = 1; p < NUM_PLL; p++)
		begin
			fvalid_d[p] = 1'b1;
			for (int b = 0; b < 4; b++)
				frac_d[p*32 + b*8 +: 8] = shadow_q[p][28 + b];
		end
	end

	// Registers
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			page_q   <= `POPC_RST_PAGE;
			drv_q    <= `POPC_RST_DRV;
			misc_q   <= `POPC_RST_MISC;
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
			cfg_q    <= '0;
			frac_q   <= '0;
			fvalid_q <= '0;
			for (int p = 0; p < NUM_PLL; p++)
				for (int i = 0; i < SH_N; i++)
					shadow_q[p][i] <= `POPC_RST_SHADOW;
		end
		else if (ce_i)
		begin
			page_q   <= page_d;
			drv_q    <= drv_d;
			misc_q   <= misc_d;
			shadow_q <= shadow_d;
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			cfg_q    <= cfg_d;
			frac_q   <= frac_d;
			fvalid_q <= fvalid_d;
		end
	end

	assign rdata_o      = rdata_q;
	assign rvalid_o     = rvalid_q;
	assign out_cfg_o    = cfg_q;
	assign frac_n2_o    = frac_q;
	assign frac_valid_o = fvalid_q;
	assign notify_o     = notify;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	sequence page_write_s;
		ce_i && req_i.wr && req_i.addr == `POPC_OFF_PAGE;
	endsequence

	page_write_a: assert property (
		page_write_s |=> page_q == $past(req_i.wdata))
		else $error("page register did not take written value");
	page_read_a: assert property (
		ce_i && req_i.rd && req_i.addr == `POPC_OFF_PAGE
		|=> rvalid_o && rdata_o == $past(page_q))
		else $error("page register readback wrong");
	page_decode_a: assert property (
		ce_i && req_i.wr && !on_out_page &&
		req_i.addr == `POPC_OFF_MISC |=> misc_q == $past(misc_q))
		else $error("misc register written off its page");
	shadow_rw_a: assert property (
		ce_i && req_i.wr && on_pll_page && in_shadow ##1
		ce_i && req_i.rd && $stable(req_i.addr) && $stable(page_q)
		|=> rdata_o == $past(req_i.wdata, 2))
		else $error("shadow byte readback wrong");
	frac_first_a: assert property (
		frac_valid_o[0] == 1'b0 && frac_n2_o[31:0] == 32'h0)
		else $error("first PLL fraction not ignored");
	drv_decode_a: assert property (
		ce_i && drv_q[2:0] == 3'h2 |=> out_cfg_o.drv == POPC_DRV_CML)
		else $error("driver standard decode wrong");
	div_hi_a: assert property (
		ce_i |=> out_cfg_o.div_hi == $past(misc_q[7:6]))
		else $error("divider upper bits not passed");
	delay_steps_a: assert property (
		ce_i |=> out_cfg_o.delay_steps <= `POPC_DLY_MAX_STEPS)
		else $error("fine delay beyond four steps");
	pin_mode_a: assert property (
		ce_i && misc_q[3:0] == 4'hc
		|=> out_cfg_o.cmos_p && out_cfg_o.cmos_n && !out_cfg_o.ext_term)
		else $error("pin-use both-CMOS decode wrong");
	status_read_a: assert property (
		ce_i && req_i.rd && on_pll_page &&
		req_i.addr == `POPC_OFF_STATUS
		|=> rdata_o == {7'h00, $past(live[pll_sel])})
		else $error("status read does not show live lock");
endmodule

// >>> sim/popc_tb.sv
// Self-checking bench for the paged configuration register bank
`timescale 1ns/1ps
module testbench
	import popc_pkg::*;
;
	logic          clock_i   = 1'b0;
	logic          reset_n_i = 1'b0;
	logic          ce_i      = 1'b1;
	popc_req_t     req       = '0;
	logic [3:0]    lol       = 4'h0;
	logic [7:0]    rdata;
	logic          rvalid;
	popc_out_cfg_t cfg;
	logic [127:0]  frac;
	logic [3:0]    fvalid;
	logic [3:0]    notify;
	int            err_total = 0;
	int            cmp_count = 0;

	// 50 MHz clock
	always #10 clock_i = ~clock_i;

	popc_config_regs #(.NUM_PLL(4)) popc_config_regs_inst (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .lol_i(lol),
		.out_cfg_o(cfg), .frac_n2_o(frac), .frac_valid_o(fvalid),
		.notify_o(notify));

	// Ends the run from either the main sequence or the watchdog
	task automatic results();
		$display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Inputs always move 1 ns after the edge, away from sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// Spare cycle after each access keeps req to one assignment per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, a, d};
		cyc(1);
		req = '0;
		cyc(1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string n);
		req = '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		req = '0;
		check("rvalid", 1, rvalid);
		check(n, e, rdata);
		cyc(1);
		check("rvalid_end", 0, rvalid);
	endtask

	// Write then read with no gap; the read must see the new byte
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
		input string n);
		req = '{1'b1, 1'b0, a, d};
		cyc(1);
		req = '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		req = '0;
		check("rvalid", 1, rvalid);
		check(n, d, rdata);
		cyc(1);
	endtask

	task automatic t_reset();
		rd(8'hff, 8'h00, "page");
		rd(8'h67, 8'h00, "misc");
		check("ext_term", 1, cfg.ext_term);
		check("div_hi", 0, cfg.div_hi);
	endtask

	// Page switch, foreign page write, frozen request under ce low
	task automatic t_page();
		wr(8'hff, 8'h01);
		rd(8'hff, 8'h01, "page");
		wr(8'h67, 8'h5a);
		rd(8'h67, 8'h00, "unmapped");
		ce_i = 1'b0;
		wr(8'hff, 8'h03);
		ce_i = 1'b1;
		rd(8'hff, 8'h01, "page");
		wr(8'hff, 8'h00);
		rd(8'h67, 8'h00, "misc");
	endtask

	task automatic t_misc();
		logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc};
		logic [4:0] flags [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03};
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h67, {4'ha, codes[i]});
			rd(8'h67, {4'ha, codes[i]}, "misc");
			check("pins", flags[i], {cfg.ext_term, cfg.pull_up,
				cfg.pull_down, cfg.cmos_p, cfg.cmos_n});
			check("pin_ok", 1, cfg.pin_ok);
			check("div_hi", 2'h2, cfg.div_hi);
		end
		wr(8'h67, 8'h03);
		check("pin_ok", 0, cfg.pin_ok);
	endtask

	// Every driver code and every fine delay code, clamped past four
	task automatic t_drv();
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h66, {3'h0, c[1:0], c[2:0]});
			wr(8'h67, {3'h0, c[2], 4'h0});
			check("drv_ok", c < 6, cfg.drv_ok);
			if (c < 6)
				check("drv", c, cfg.drv);
			check("delay", c > 4 ? 4 : c, cfg.delay_steps);
		end
	endtask

	// First PLL must keep its fraction at zero, the second honours it
	task automatic t_frac();
		wr(8'hff, 8'h01);
		wr(8'h10, 8'ha5);
		rd(8'h10, 8'ha5, "shadow");
		wr_rd(8'h11, 8'h5a, "shadow");
		for (int p = 0; p < 2; p++)
		begin
			wr(8'hff, p[7:0] + 8'h01);
			for (int b = 0; b < 4; b++)
				wr(8'h2c + b[7:0], b[7:0] * 8'h11 + 8'h11);
			rd(8'h2f, 8'h44, "shadow");
			check("frac", p == 0 ? 0 : 32'h44332211, frac[p*32 +: 32]);
			check("frac_valid", p != 0, fvalid[p]);
		end
	endtask

	task automatic t_lock();
		wr(8'hff, 8'h01);
		rd(8'h02, 8'h00, "status");
		lol[0] = 1'b1;
		cyc(6);
		rd(8'h02, 8'h01, "status");
		wr(8'h02, 8'h00);
		rd(8'h02, 8'h01, "status");
		check("notify", 0, notify[0]);
		wr(8'h04, 8'h00);
		cyc(1);
		check("notify", 1, notify[0]);
		wr(8'h03, 8'h01);
		rd(8'h03, 8'h01, "sticky");
		lol[0] = 1'b0;
		cyc(6);
		rd(8'h02, 8'h00, "status");
		check("notify", 1, notify[0]);
		wr(8'h03, 8'h01);
		cyc(1);
		check("notify", 0, notify[0]);
		rd(8'h03, 8'h00, "sticky");
		lol[0] = 1'b1;
		cyc(8);
		check("notify", 1, notify[0]);
		lol[0] = 1'b0;
	endtask

	// Main sequence
	initial
	begin
		cyc(4);
		reset_n_i = 1'b1;
		cyc(1);
		t_reset();
		t_page();
		t_misc();
		t_drv();
		t_frac();
		t_lock();
		results();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#100000;
		err_total++;
		results();
	end
endmodule
